/* File: hw/tl_link.sv */
// Purpose: Drive-side link layer of the tape library serial link, Avalon-MM registers.
// Assumes: One 100 MHz clock; serial line and switches asynchronous to it.
// Notes: Software moves message bytes; framing, stuffing, checks and retries are here.
// Contract
// - Non-polled: drive may send any time
// - Polled: drive sends only when polled
// - Startup handshake sets mode; switch gives default
// - Bit rate 9600 or 38400 by switch
// - Eight data bits, no parity, 1/2 stops
// - Transmit and receive run independently
// - Type primitives are raw, unframed bytes
// - Reply: five header bytes, revision MSB first
// - Packet opens 0x02, closes 0x03
// - ACK 0x06 when length and checksum good
// - NAK 0x15 on length or checksum error
// - On NAK resend at once, three retries
// - Busy receiver answers 0x1A
// - On busy wait ten seconds, ten retries
// - NAK packets until handshake completes
// - Other messages framed; replies stay short
// - Self-test bytes ending 0x03 discarded
// - Send 0x03 before first real message
// - Replies are code then end character
// - Five second reply wait, three retries
`timescale 1ns/1ps
`include "tl_link_cfg.svh"

module tl_link
  import tl_pkg::*;
#(
  parameter logic [15:0] BIT_CYC_SLOW = 16'(`TL_BIT_CYC(`TL_BAUD_SLOW)),
  parameter logic [15:0] BIT_CYC_FAST = 16'(`TL_BIT_CYC(`TL_BAUD_FAST)),
  parameter logic [31:0] RESP_CYC = 32'(`TL_RESP_CYC),
  parameter logic [31:0] BUSY_CYC = 32'(`TL_BUSY_CYC),
  parameter logic [39:0] TYPE_HEADER = 40'h5a_c3_11_22_01 // Arbitrary identification value
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_rx,
  output logic serial_tx,
  input wire logic sw_baud_fast,
  input wire logic sw_two_stop,
  input wire logic sw_polled_default
);

  logic rst_s1_q, rst_n_q;
  logic [3:0] in_s1_q, in_s2_q, in_s3_q, in_f_q;
  tl_sw_s sw;
  logic rx_line;
  logic [15:0] bit_cyc;
  logic [2:0] init_q;
  logic hs_done_q, polled_q, may_send_q;
  logic ack_q, take_wr, take_rd;
  logic [31:0] rdata_q, fw_rev_q;
  logic ctrl_wr, go_ok;
  logic rx_busy_q, rx_v_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q, rx_b_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_cnt_q;
  logic tx_idle, tx_go;
  logic [7:0] tx_byte;
  tl_parse_e ps_q;
  logic [9:0] pptr_q, rx_len_q, rx_rptr_q;
  logic [7:0] psum_q, plast_q;
  logic [15:0] plen_q;
  logic perr_q, p_clr, st_en, esc_bad, pkt_end, pkt_good;
  logic [7:0] st_b, pcode_q;
  tl_resp_s resp;
  logic [7:0] rx_mem [0:511];
  logic rx_ready_q, reply_pend_q, type_pend_q, mark_pend_q;
  logic [7:0] reply_code_q;
  tl_seq_e sq_q;
  logic [9:0] sidx_q, tx_len_q, tx_wptr_q;
  logic sesc_q, frame_done;
  logic [7:0] bcc_q, raw_b;
  logic [7:0] tx_mem [0:511];
  tl_pk_e pk_q;
  logic [31:0] tmr_q;
  logic [1:0] ncnt_q;
  logic [3:0] bcnt_q;
  logic tx_ok_q, tx_err_q;

  // Stuffed characters need an escape prefix
  function automatic logic tl_special(input logic [7:0] b);
    tl_special = (b == `TL_CH_STX) || (b == `TL_CH_ETX) || (b == `TL_CH_ESC);
  endfunction : tl_special

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      in_s1_q <= 4'h1;
      in_s2_q <= 4'h1;
      in_s3_q <= 4'h1;
      in_f_q <= 4'h1;
    end else begin
      in_s1_q <= {sw_polled_default, sw_two_stop, sw_baud_fast, serial_rx};
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      in_f_q <= (in_s2_q & in_s3_q) | (in_f_q & (in_s2_q ^ in_s3_q));
    end
  end

  assign rx_line = in_f_q[0];
  assign sw = tl_sw_s'(in_f_q[3:1]);
  assign bit_cyc = sw.baud_fast ? BIT_CYC_FAST : BIT_CYC_SLOW;

  // Avalon slave: one wait state, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign take_wr = avs_write & ack_q;
  assign take_rd = avs_read & ack_q;
  assign avs_readdata = rdata_q;
  assign ctrl_wr = take_wr && (avs_address == `TL_REG_CTRL);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q) begin
        case (avs_address)
          `TL_REG_CTRL: rdata_q <= {30'h0, polled_q, hs_done_q};
          `TL_REG_STATUS: rdata_q <= {25'h0, may_send_q, hs_done_q, polled_q, rx_ready_q,
                                      tx_err_q, tx_ok_q, pk_q != TL_K_IDLE};
          `TL_REG_FW_REV: rdata_q <= fw_rev_q;
          `TL_REG_TX_LEN: rdata_q <= {22'h0, tx_len_q};
          `TL_REG_RX_LEN: rdata_q <= {22'h0, rx_len_q};
          `TL_REG_RX_DATA: rdata_q <= {24'h0, rx_mem[rx_rptr_q[8:0]]};
          default: rdata_q <= 32'h0; // Unmapped reads return zero
        endcase
      end
    end
  end

  // Mode and handshake state; default mode caught once the switch filter settles
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      init_q <= 3'd0;
      hs_done_q <= 1'b0;
      polled_q <= 1'b0;
      fw_rev_q <= 32'h0;
      tx_len_q <= 10'h0;
    end else begin
      if (init_q != `TL_INIT_WAIT) begin
        init_q <= init_q + 3'd1;
        if (init_q == `TL_INIT_WAIT - 3'd1) polled_q <= sw.polled_default;
      end
      if (ctrl_wr) begin
        hs_done_q <= avs_writedata[`TL_CTRL_HS_DONE];
        polled_q <= avs_writedata[`TL_CTRL_POLLED];
      end
      if (take_wr && avs_address == `TL_REG_FW_REV) fw_rev_q <= avs_writedata;
      if (take_wr && avs_address == `TL_REG_TX_LEN) tx_len_q <= avs_writedata[9:0];
    end
  end

  // Receive UART: mid-bit sampling, first stop bit checked
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h0;
      rx_v_q <= 1'b0;
      rx_b_q <= 8'h0;
    end else begin
      rx_v_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_line) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= {1'b0, bit_cyc[15:1]};
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0) begin
        rx_cnt_q <= rx_cnt_q - 16'h1;
      end else begin
        rx_cnt_q <= bit_cyc - 16'h1;
        if (rx_bit_q == 4'h0) begin
          if (rx_line) rx_busy_q <= 1'b0; // Glitch, not a start bit
          else rx_bit_q <= 4'h1;
        end else if (rx_bit_q <= 4'h8) begin
          rx_sh_q <= {rx_line, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 4'h1;
        end else begin
          rx_busy_q <= 1'b0;
          rx_v_q <= rx_line; // Framing errors drop the byte
          rx_b_q <= rx_sh_q;
        end
      end
    end
  end

  // Transmit UART; runs beside the receiver with no shared state
  assign tx_idle = (tx_left_q == 4'h0);
  assign serial_tx = tx_sh_q[0];

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_sh_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 16'h0;
    end else if (tx_go) begin
      tx_sh_q <= {2'b11, tx_byte, 1'b0};
      tx_left_q <= sw.two_stop ? 4'd11 : 4'd10;
      tx_cnt_q <= bit_cyc - 16'h1;
    end else if (!tx_idle) begin
      if (tx_cnt_q != 16'h0) begin
        tx_cnt_q <= tx_cnt_q - 16'h1;
      end else begin
        tx_cnt_q <= bit_cyc - 16'h1;
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
    end
  end

  // Byte parser: hunt, collect, unstuff, spot replies
  always_comb begin
    p_clr = 1'b0;
    st_en = 1'b0;
    st_b = rx_b_q;
    esc_bad = 1'b0;
    pkt_end = 1'b0;
    resp = '0;
    if (rx_v_q) begin
      case (ps_q)
        TL_P_IDLE: p_clr = (rx_b_q == `TL_CH_STX);
        TL_P_RESP: begin
          p_clr = (rx_b_q == `TL_CH_STX);
          resp.ack = (rx_b_q == `TL_CH_ETX) && (pcode_q == `TL_CH_ACK);
          resp.nak = (rx_b_q == `TL_CH_ETX) && (pcode_q == `TL_CH_NAK);
          resp.busy = (rx_b_q == `TL_CH_ETX) && (pcode_q == `TL_CH_BUSY);
        end
        TL_P_PKT: begin
          p_clr = (rx_b_q == `TL_CH_STX);
          pkt_end = (rx_b_q == `TL_CH_ETX);
          st_en = !p_clr && !pkt_end && (rx_b_q != `TL_CH_ESC);
        end
        TL_P_ESC: begin
          p_clr = (rx_b_q == `TL_CH_STX);
          pkt_end = (rx_b_q == `TL_CH_ETX);
          st_en = (rx_b_q == `TL_CH_ESC_STX) || (rx_b_q == `TL_CH_ESC_ETX) ||
                  (rx_b_q == `TL_CH_ESC);
          esc_bad = !st_en && !p_clr && !pkt_end;
          st_b = (rx_b_q == `TL_CH_ESC_STX) ? `TL_CH_STX :
                 (rx_b_q == `TL_CH_ESC_ETX) ? `TL_CH_ETX : `TL_CH_ESC;
        end
        default: p_clr = 1'b0;
      endcase
    end
  end

  // Length counts message bytes only; checksum excludes the trailing check byte
  assign pkt_good = !perr_q && (pptr_q >= 10'd3) && (psum_q == plast_q) &&
                    (plen_q == {6'h0, pptr_q - 10'd3});

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ps_q <= TL_P_IDLE;
      pcode_q <= 8'h0;
    end else if (rx_v_q) begin
      case (ps_q)
        TL_P_IDLE, TL_P_RESP: begin
          if (rx_b_q == `TL_CH_STX) ps_q <= TL_P_PKT;
          else if (rx_b_q == `TL_CH_ACK || rx_b_q == `TL_CH_NAK || rx_b_q == `TL_CH_BUSY) begin
            ps_q <= TL_P_RESP;
            pcode_q <= rx_b_q;
          end else ps_q <= TL_P_IDLE; // Stray text and a lone end are dropped
        end
        TL_P_PKT: if (pkt_end) ps_q <= TL_P_IDLE;
          else if (rx_b_q == `TL_CH_ESC) ps_q <= TL_P_ESC;
        TL_P_ESC: ps_q <= pkt_end ? TL_P_IDLE : TL_P_PKT;
        default: ps_q <= TL_P_IDLE;
      endcase
    end
  end

  // Packet collection; the buffer is frozen while software still owns it
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pptr_q <= 10'h0;
      psum_q <= 8'h0;
      plast_q <= 8'h0;
      plen_q <= 16'h0;
      perr_q <= 1'b0;
    end else if (p_clr) begin
      pptr_q <= 10'h0;
      psum_q <= 8'h0;
      perr_q <= 1'b0;
    end else if (esc_bad) begin
      perr_q <= 1'b1;
    end else if (st_en) begin
      if (pptr_q == `TL_RX_MAX) perr_q <= 1'b1;
      else pptr_q <= pptr_q + 10'h1;
      if (pptr_q != 10'h0) psum_q <= psum_q + plast_q;
      plast_q <= st_b;
      if (pptr_q == 10'h0) plen_q[15:8] <= st_b;
      if (pptr_q == 10'h1) plen_q[7:0] <= st_b;
    end
  end

  always_ff @(posedge clock) begin
    if (st_en && !rx_ready_q && pptr_q != `TL_RX_MAX) rx_mem[pptr_q[8:0]] <= st_b;
  end

  // Verdict on each packet end and software ownership of the receive buffer
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_ready_q <= 1'b0;
      rx_len_q <= 10'h0;
      rx_rptr_q <= `TL_RX_RPTR_INIT;
      reply_pend_q <= 1'b0;
      reply_code_q <= `TL_CH_NAK;
      type_pend_q <= 1'b0;
      may_send_q <= 1'b0;
    end else begin
      if (take_rd && avs_address == `TL_REG_RX_DATA) rx_rptr_q <= rx_rptr_q + 10'h1;
      if (ctrl_wr && avs_writedata[`TL_CTRL_RX_RELEASE]) rx_ready_q <= 1'b0;
      if (sq_q == TL_S_REPLY && tx_go && sidx_q != 10'h0) reply_pend_q <= 1'b0;
      if (sq_q == TL_S_TYPE && tx_go && sidx_q == `TL_TYPE_LAST) type_pend_q <= 1'b0;
      if (go_ok) may_send_q <= 1'b0;
      if (rx_v_q && ps_q == TL_P_IDLE && rx_b_q == `TL_CH_QUERY) type_pend_q <= 1'b1;
      if (pkt_end) begin
        reply_pend_q <= 1'b1; // Newest verdict wins over a reply being retired
        if (rx_ready_q) reply_code_q <= `TL_CH_BUSY;
        else if (!pkt_good || !hs_done_q) reply_code_q <= `TL_CH_NAK;
        else begin
          reply_code_q <= `TL_CH_ACK;
          rx_ready_q <= 1'b1;
          rx_len_q <= plen_q[9:0];
          rx_rptr_q <= `TL_RX_RPTR_INIT;
          may_send_q <= 1'b1; // A polled answer is now allowed
        end
      end
    end
  end

  // Transmit byte source per sequencer state
  always_comb begin
    if (sidx_q == 10'h0) raw_b = `TL_CH_STX;
    else if (sidx_q == 10'h1) raw_b = {7'h0, tx_len_q[8]};
    else if (sidx_q == 10'h2) raw_b = tx_len_q[7:0];
    else if (sidx_q < tx_len_q + 10'd3) raw_b = tx_mem[9'(sidx_q - 10'd3)];
    else if (sidx_q == tx_len_q + 10'd3) raw_b = bcc_q;
    else raw_b = `TL_CH_ETX;
    tx_byte = 8'h0;
    case (sq_q)
      TL_S_MARK: tx_byte = `TL_CH_ETX;
      TL_S_REPLY: tx_byte = (sidx_q == 10'h0) ? reply_code_q : `TL_CH_ETX;
      TL_S_TYPE: tx_byte = (sidx_q <= `TL_HDR_LAST) ?
                           TYPE_HEADER[8'(39 - 8 * sidx_q) -: 8] :
                           fw_rev_q[8'(31 - 8 * (sidx_q - 10'd5)) -: 8];
      TL_S_FRAME: begin
        if (sidx_q == 10'h0 || sidx_q > tx_len_q + 10'd3) tx_byte = raw_b;
        else if (sesc_q) tx_byte = (raw_b == `TL_CH_STX) ? `TL_CH_ESC_STX :
                                   (raw_b == `TL_CH_ETX) ? `TL_CH_ESC_ETX : `TL_CH_ESC;
        else if (tl_special(raw_b)) tx_byte = `TL_CH_ESC;
        else tx_byte = raw_b;
      end
      default: tx_byte = 8'h0;
    endcase
  end

  assign tx_go = tx_idle && (sq_q != TL_S_IDLE);
  assign frame_done = tx_go && (sq_q == TL_S_FRAME) && (sidx_q == tx_len_q + 10'd4);

  // Sequencer: replies never cut into a frame; a frame waits for the line
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sq_q <= TL_S_IDLE;
      sidx_q <= 10'h0;
      sesc_q <= 1'b0;
      bcc_q <= 8'h0;
      mark_pend_q <= 1'b1;
    end else begin
      case (sq_q)
        TL_S_IDLE: begin
          sidx_q <= 10'h0;
          sesc_q <= 1'b0;
          bcc_q <= 8'h0;
          if (mark_pend_q) sq_q <= TL_S_MARK;
          else if (reply_pend_q) sq_q <= TL_S_REPLY; // Short reply, no framing
          else if (type_pend_q) sq_q <= TL_S_TYPE;
          else if (pk_q == TL_K_SEND) sq_q <= TL_S_FRAME;
        end
        TL_S_MARK: if (tx_go) begin
          mark_pend_q <= 1'b0;
          sq_q <= TL_S_IDLE;
        end
        TL_S_REPLY, TL_S_TYPE: if (tx_go) begin
          sidx_q <= sidx_q + 10'h1;
          if ((sq_q == TL_S_REPLY && sidx_q != 10'h0) || sidx_q == `TL_TYPE_LAST)
            sq_q <= TL_S_IDLE;
        end
        TL_S_FRAME: if (tx_go) begin
          if (sidx_q != 10'h0 && sidx_q <= tx_len_q + 10'd3 && !sesc_q && tl_special(raw_b)) begin
            sesc_q <= 1'b1;
          end else begin
            sesc_q <= 1'b0;
            sidx_q <= sidx_q + 10'h1;
            if (sidx_q != 10'h0 && sidx_q < tx_len_q + 10'd3) bcc_q <= bcc_q + raw_b;
            if (frame_done) sq_q <= TL_S_IDLE;
          end
        end
        default: sq_q <= TL_S_IDLE;
      endcase
    end
  end

  // Message bytes from software, appended in order
  always_ff @(posedge clock) begin
    if (take_wr && avs_address == `TL_REG_TX_DATA) tx_mem[tx_wptr_q[8:0]] <= avs_writedata[7:0];
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) tx_wptr_q <= 10'h0;
    else if (go_ok) tx_wptr_q <= 10'h0;
    else if (take_wr && avs_address == `TL_REG_TX_DATA) tx_wptr_q <= tx_wptr_q + 10'h1;
  end

  // Send request is refused in polled mode unless a packet invited it
  assign go_ok = ctrl_wr && avs_writedata[`TL_CTRL_GO] && (pk_q == TL_K_IDLE) &&
                 (!polled_q || may_send_q);

  // Packet sender: reply wait, retries, busy back-off
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pk_q <= TL_K_IDLE;
      tmr_q <= 32'h0;
      ncnt_q <= 2'h0;
      bcnt_q <= 4'h0;
      tx_ok_q <= 1'b0;
      tx_err_q <= 1'b0;
    end else begin
      case (pk_q)
        TL_K_IDLE: if (go_ok) begin
          pk_q <= TL_K_SEND;
          ncnt_q <= 2'h0;
          bcnt_q <= 4'h0;
          tx_ok_q <= 1'b0;
          tx_err_q <= 1'b0;
        end
        TL_K_SEND: if (frame_done) begin
          pk_q <= TL_K_WAIT;
          tmr_q <= RESP_CYC;
        end
        TL_K_WAIT: begin
          tmr_q <= tmr_q - 32'h1;
          if (resp.ack) begin
            pk_q <= TL_K_IDLE;
            tx_ok_q <= 1'b1;
          end else if (resp.busy) begin
            if (bcnt_q == `TL_BUSY_RETRIES) begin
              pk_q <= TL_K_IDLE;
              tx_err_q <= 1'b1;
            end else begin
              bcnt_q <= bcnt_q + 4'h1;
              pk_q <= TL_K_HOLD;
              tmr_q <= BUSY_CYC;
            end
          end else if (resp.nak || tmr_q == 32'h0) begin
            if (ncnt_q == `TL_NAK_RETRIES) begin
              pk_q <= TL_K_IDLE;
              tx_err_q <= 1'b1;
            end else begin
              ncnt_q <= ncnt_q + 2'h1;
              pk_q <= TL_K_SEND;
            end
          end
        end
        TL_K_HOLD: begin
          tmr_q <= tmr_q - 32'h1;
          if (tmr_q == 32'h0) pk_q <= TL_K_SEND;
        end
        default: pk_q <= TL_K_IDLE;
      endcase
    end
  end

endmodule : tl_link

/* File: hw/tl_link_cfg.svh */
// Purpose: Constants of the tape library serial link: offsets, bits, codes, timing.
// Assumes: 100 MHz system clock; byte addresses on the register bus.
// Notes: Definitions only.
`ifndef TL_LINK_CFG_SVH
`define TL_LINK_CFG_SVH

// Register byte offsets
`define TL_REG_CTRL 5'h00
`define TL_REG_STATUS 5'h04
`define TL_REG_FW_REV 5'h08
`define TL_REG_TX_LEN 5'h0c
`define TL_REG_TX_DATA 5'h10
`define TL_REG_RX_LEN 5'h14
`define TL_REG_RX_DATA 5'h18

// Control register bits
`define TL_CTRL_HS_DONE 0
`define TL_CTRL_POLLED 1
`define TL_CTRL_GO 2
`define TL_CTRL_RX_RELEASE 3

// Status register bits
`define TL_ST_TX_BUSY 0
`define TL_ST_TX_OK 1
`define TL_ST_TX_ERR 2
`define TL_ST_RX_READY 3
`define TL_ST_POLLED 4
`define TL_ST_HS_DONE 5
`define TL_ST_MAY_SEND 6

// Link characters
`define TL_CH_QUERY 8'h00
`define TL_CH_STX 8'h02
`define TL_CH_ETX 8'h03
`define TL_CH_ACK 8'h06
`define TL_CH_NAK 8'h15
`define TL_CH_BUSY 8'h1a
`define TL_CH_ESC 8'hff
`define TL_CH_ESC_STX 8'hf2
`define TL_CH_ESC_ETX 8'hf3

// Retry limits and sizes
`define TL_NAK_RETRIES 2'd3
`define TL_BUSY_RETRIES 4'd10
`define TL_RX_MAX 10'd510
`define TL_RX_RPTR_INIT 10'd2
`define TL_TYPE_LAST 10'd8
`define TL_HDR_LAST 10'd4
`define TL_INIT_WAIT 3'd7

// Timing figures and derived cycle counts
`define TL_CLK_HZ 64'd100000000
`define TL_BAUD_SLOW 64'd9600
`define TL_BAUD_FAST 64'd38400
`define TL_RESP_TIMEOUT_S 64'd5
`define TL_BUSY_DELAY_S 64'd10
`define TL_BIT_CYC(b) ((`TL_CLK_HZ + (b) / 64'd2) / (b))
`define TL_RESP_CYC (`TL_RESP_TIMEOUT_S * `TL_CLK_HZ)
`define TL_BUSY_CYC (`TL_BUSY_DELAY_S * `TL_CLK_HZ)

`endif

/* File: hw/tl_pkg.sv */
// Purpose: Types shared by the tape library serial link.
// Assumes: Constants live in tl_link_cfg.svh.
// Notes: One-hot state encodings.
package tl_pkg;

  typedef enum logic [3:0] {
    TL_P_IDLE = 4'b0001,
    TL_P_PKT = 4'b0010,
    TL_P_ESC = 4'b0100,
    TL_P_RESP = 4'b1000
  } tl_parse_e;

  typedef enum logic [4:0] {
    TL_S_IDLE = 5'b00001,
    TL_S_MARK = 5'b00010,
    TL_S_REPLY = 5'b00100,
    TL_S_TYPE = 5'b01000,
    TL_S_FRAME = 5'b10000
  } tl_seq_e;

  typedef enum logic [3:0] {
    TL_K_IDLE = 4'b0001,
    TL_K_SEND = 4'b0010,
    TL_K_WAIT = 4'b0100,
    TL_K_HOLD = 4'b1000
  } tl_pk_e;

  // Filtered configuration switches
  typedef struct packed {
    logic polled_default;
    logic two_stop;
    logic baud_fast;
  } tl_sw_s;

  // Replies seen from the library
  typedef struct packed {
    logic ack;
    logic nak;
    logic busy;
  } tl_resp_s;

endpackage : tl_pkg

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench of tl_link.
// Assumes: Short bit period and timeouts via parameters.
// Notes: Library end is tl_lib_model.
`timescale 1ns/1ps
`include "tl_link_cfg.svh"
module tb_top;
  localparam logic [39:0] HDR = 40'h5ac3112201; // Arbitrary identification value
  localparam logic [87:0] PKT = 88'h02_00_06_10_11_12_13_14_15_75_03;
  localparam logic [95:0] FRM = 96'h02_00_06_ff_f2_21_22_23_24_25_b7_03;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic serial_rx;
  logic serial_tx;
  logic sw_baud_fast = 1'b0, sw_two_stop = 1'b0, sw_polled_default = 1'b0;
  logic [31:0] rd;
  int errors = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  tl_link #(.BIT_CYC_SLOW(16'h10), .BIT_CYC_FAST(16'h10), .RESP_CYC(32'd20000),
    .BUSY_CYC(32'd500), .TYPE_HEADER(HDR)) u_dut (.clock(clock), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .sw_baud_fast(sw_baud_fast), .sw_two_stop(sw_two_stop),
    .sw_polled_default(sw_polled_default));
  tl_lib_model #(.BIT(16)) u_lib (.clock(clock), .line_out(serial_rx), .line_in(serial_tx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rx_exp(input logic [95:0] v, input int n);
    logic [7:0] b;
    for (int i = n - 1; i >= 0; i--) begin
      while (u_lib.rxq.size() == 0) @(posedge clock);
      b = u_lib.rxq.pop_front();
      chk({24'h0, b}, {24'h0, v[i*8 +: 8]});
    end
  endtask : rx_exp
  task automatic tx_seq(input logic [111:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) u_lib.send(v[i*8 +: 8]);
  endtask : tx_seq
  task automatic t_query;
    bus(1'b1, `TL_REG_FW_REV, 32'h12345678);
    bus(1'b0, 5'h1c, 32'h0);
    bus(1'b0, `TL_REG_TX_DATA, 32'h0);
    u_lib.send(`TL_CH_QUERY);
    rx_exp({HDR, 32'h12345678}, 9);
  endtask : t_query
  task automatic t_accept;
    tx_seq(PKT, 11);
    rx_exp(16'h1503, 2);
    bus(1'b1, `TL_REG_CTRL, 32'h1);
    tx_seq({24'h550201, PKT}, 14);
    rx_exp(16'h0603, 2);
    bus(1'b0, `TL_REG_RX_LEN, 32'h0);
    chk(rd, 32'h6);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, `TL_REG_RX_DATA, 32'h0);
      chk(rd, 32'h10 + i);
    end
    tx_seq(PKT, 11);
    rx_exp(16'h1a03, 2);
    bus(1'b1, `TL_REG_CTRL, 32'h9);
    tx_seq({PKT[87:16], 16'h7603}, 11);
    rx_exp(16'h1503, 2);
  endtask : t_accept
  task automatic t_send;
    bus(1'b1, `TL_REG_TX_LEN, 32'h6);
    bus(1'b1, `TL_REG_TX_DATA, 32'h2);
    for (int i = 1; i < 6; i++) bus(1'b1, `TL_REG_TX_DATA, 32'h20 + i);
    bus(1'b1, `TL_REG_CTRL, 32'h5);
    rx_exp(FRM, 12);
    tx_seq(16'h1503, 2);
    rx_exp(FRM, 12);
    tx_seq(16'h0603, 2);
    do bus(1'b0, `TL_REG_STATUS, 32'h0); while (rd[0] === 1'b1);
    chk({29'h0, rd[2:0]}, 32'h2);
    bus(1'b1, `TL_REG_CTRL, 32'h3);
    bus(1'b1, `TL_REG_CTRL, 32'h7);
    bus(1'b0, `TL_REG_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
  endtask : t_send
  task automatic t_reset;
    {sw_polled_default, sw_two_stop, sw_baud_fast} <= 3'h7;
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rx_exp(8'h03, 1);
    bus(1'b0, `TL_REG_CTRL, 32'h0);
    chk(rd, 32'h2);
  endtask : t_reset
  task automatic summarize;
    $display("errors=%0d num_checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    rx_exp(8'h03, 1);
    t_query();
    t_accept();
    t_send();
    t_reset();
    summarize();
  end
  // Whole run needs about 15000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    summarize();
  end
endmodule : tb_top

/* File: verif/tl_lib_model.sv */
// Purpose: Library controller end of the serial line.
// Assumes: Same bit period as the drive.
// Notes: Bytes sent on command, bytes heard queued.
`timescale 1ns/1ps
module tl_lib_model #(
  parameter int BIT = 16
) (
  input wire logic clock,
  output logic line_out,
  input wire logic line_in
);
  logic [7:0] rxq[$];
  // One character, LSB first, one stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clock);
    end
  endtask : send
  // Receiver runs on its own so both directions overlap
  initial begin : rx
    logic [7:0] b;
    line_out = 1'b1;
    forever begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock);
        b[i] = line_in;
      end
      repeat (BIT) @(posedge clock);
      rxq.push_back(b);
    end
  end
endmodule : tl_lib_model

/* File: verif/tl_link_assertions.sv */
// Purpose: Port assertions for tl_link.
// Assumes: Baud switch static while a character is on the line.
// Notes: Bound to every tl_link instance.
`timescale 1ns/1ps
`include "tl_link_cfg.svh"
module tl_link_assertions #(
  parameter logic [15:0] BIT_CYC_SLOW = 16'h10,
  parameter logic [15:0] BIT_CYC_FAST = 16'h10
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic serial_tx,
  input wire logic sw_baud_fast
);
  logic [15:0] bit_c;
  logic [15:0] pos_q;
  logic tx_q;
  logic rd_ok;
  assign bit_c = sw_baud_fast ? BIT_CYC_FAST : BIT_CYC_SLOW;
  assign rd_ok = avs_read && !avs_waitrequest;
  // Cycle count inside an outgoing character; mid-bit checks absorb the one-cycle edge-detect lag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= 16'h0;
      tx_q <= 1'b1;
    end else begin
      tx_q <= serial_tx;
      if (pos_q != 16'h0) begin
        pos_q <= (pos_q == 16'(10 * bit_c - 1)) ? 16'h0 : pos_q + 16'h1;
      end else if (tx_q && !serial_tx) begin
        pos_q <= 16'h1;
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  property p_first_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("no stall in first cycle");
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("stall longer than one cycle");
  property p_idle_wait;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("stall without request");
  property p_hole_zero;
    rd_ok && avs_address == 5'h1c |-> avs_readdata == 32'h0;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  property p_txd_zero;
    rd_ok && avs_address == `TL_REG_TX_DATA |-> avs_readdata == 32'h0;
  endproperty
  a_txd_zero: assert property (p_txd_zero) else $error("write-only read not zero");
  property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
  property p_start_hold;
    pos_q == 16'h2 |-> (!serial_tx) [*8];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start bit short");
  property p_stop_high;
    pos_q == 16'(9 * bit_c + bit_c / 2) |-> serial_tx;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
  c_char: cover property (pos_q == 16'h1);
  c_wr: cover property (avs_write && !avs_waitrequest);
  c_rd: cover property (rd_ok);
endmodule : tl_link_assertions

bind tl_link tl_link_assertions #(
  .BIT_CYC_SLOW(BIT_CYC_SLOW),
  .BIT_CYC_FAST(BIT_CYC_FAST)
) u_chk (
  .clock(clock),
  .arst_n(arst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .serial_tx(serial_tx),
  .sw_baud_fast(sw_baud_fast)
);
